// ==== common/rbwf_pkg.sv ====
package rbwf_pkg;

	// readback word geometry
	localparam int RBWF_WORD_BITS = 16;
	localparam int RBWF_DATA_BITS = 12;
	localparam int RBWF_CHAN_BITS = 3;

	// field positions inside the readback word
	localparam int RBWF_KIND_POS = 15;
	localparam int RBWF_CHAN_MSB = 14;
	localparam int RBWF_CHAN_LSB = 12;
	localparam int RBWF_TAG_MSB = 15;
	localparam int RBWF_TAG_LSB = 12;
	localparam int RBWF_DATA_MSB = 11;
	localparam int RBWF_DATA_LSB = 0;

	// fixed tag values
	localparam logic RBWF_CONV_FLAG = 1'h0;
	localparam logic RBWF_OUTSET_FLAG = 1'h1;
	localparam logic [3:0] temperature_tag = 4'h8;

	// index of the last bit in a serial frame and counter width
	localparam int RBWF_CNT_BITS = 5;
	localparam logic [RBWF_CNT_BITS-1:0] RBWF_LAST_BIT = 5'h0f;

	// reset values
	localparam logic [RBWF_WORD_BITS-1:0] RBWF_WORD_RST = 16'h0000;
	localparam logic [RBWF_CNT_BITS-1:0] RBWF_CNT_RST = 5'h00;
	localparam logic [2:0] RBWF_SCLK_SYNC_RST = 3'h0;
	localparam logic [2:0] RBWF_CS_SYNC_RST = 3'h7;

	// kinds of readback word
	typedef enum logic [1:0]
	{
		RBWF_KIND_CONV,
		RBWF_KIND_TEMP,
		RBWF_KIND_OUTSET
	} rbwf_kind_t;

	// frame states
	typedef enum logic [1:0]
	{
		RBWF_IDLE,
		RBWF_SHIFT,
		RBWF_DONE
	} rbwf_state_t;

endpackage

// ==== core/rbwf_formatter.sv ====
// Overview of operation
// RULE1: conversion result words carry zero in bit 15.
// RULE2: conversion words hold the input channel number in bits 14 to 12.
// RULE3: conversion words hold the 12-bit conversion value in bits 11 to 0.
// RULE4: temperature words carry code 1000 in bits 15 to 12.
// RULE5: temperature words hold the 12-bit temperature value in bits 11 to 0.
// RULE6: output-setting readback words carry one in bit 15.
// RULE7: output-setting words hold the reported channel number in bits 14 to 12.
// RULE8: output-setting words hold that channel's 12-bit input register value.
// RULE9: words shift out msb first; host captures all 16 bits first.
`timescale 1ns/1ps
module rbwf_formatter
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// word source
	input wire logic load_valid,
	input wire rbwf_pkg::rbwf_kind_t load_kind,
	input wire logic [2:0] load_channel,
	input wire logic [11:0] load_value,
	output logic load_ready,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	output logic sdo,
	output logic sdo_oe,
	// status
	output logic frame_busy,
	output logic word_sent
);

	// builds one readback word from kind, channel and value
	function automatic logic [15:0] rbwf_format
	(
		input rbwf_pkg::rbwf_kind_t kind,
		input logic [2:0] chan,
		input logic [11:0] value
	);
		logic [15:0] w;
		w = rbwf_pkg::RBWF_WORD_RST;
		case (kind)
			rbwf_pkg::RBWF_KIND_TEMP:
			begin
				// RULE4: fixed temperature code
				w[rbwf_pkg::RBWF_TAG_MSB:rbwf_pkg::RBWF_TAG_LSB] = rbwf_pkg::temperature_tag;
				// RULE5: temperature value
				w[rbwf_pkg::RBWF_DATA_MSB:rbwf_pkg::RBWF_DATA_LSB] = value;
			end
			rbwf_pkg::RBWF_KIND_OUTSET:
			begin
				// RULE6: output flag set
				w[rbwf_pkg::RBWF_KIND_POS] = rbwf_pkg::RBWF_OUTSET_FLAG;
				// RULE7: reported channel number
				w[rbwf_pkg::RBWF_CHAN_MSB:rbwf_pkg::RBWF_CHAN_LSB] = chan;
				// RULE8: input register value
				w[rbwf_pkg::RBWF_DATA_MSB:rbwf_pkg::RBWF_DATA_LSB] = value;
			end
			default:
			begin
				// RULE1: conversion flag clear
				w[rbwf_pkg::RBWF_KIND_POS] = rbwf_pkg::RBWF_CONV_FLAG;
				// RULE2: source channel number
				w[rbwf_pkg::RBWF_CHAN_MSB:rbwf_pkg::RBWF_CHAN_LSB] = chan;
				// RULE3: conversion value
				w[rbwf_pkg::RBWF_DATA_MSB:rbwf_pkg::RBWF_DATA_LSB] = value;
			end
		endcase
		return w;
	endfunction

	// pin synchronisers and filtered levels
	logic [2:0] sclk_sync;
	logic [2:0] cs_sync;
	logic sclk_filt;
	logic cs_n_filt;
	logic [2:0] next_sclk_sync;
	logic [2:0] next_cs_sync;
	logic next_sclk_filt;
	logic next_cs_n_filt;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	// pending word
	logic [15:0] pend_word;
	logic pend_valid;
	logic [15:0] next_pend_word;
	logic next_pend_valid;

	// frame control
	rbwf_pkg::rbwf_state_t state;
	rbwf_pkg::rbwf_state_t next_state;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic next_word_sent;
	logic sh_load;
	logic sh_shift;
	logic [15:0] sh_word;
	logic sh_bit;

	// pins shift in through three flops; the filtered level moves
	// only when the second and third agree, which hides one-cycle glitches
	always_comb
	begin
		next_sclk_sync = {sclk_sync[1:0], sclk};
		next_cs_sync = {cs_sync[1:0], cs_n};
		next_sclk_filt = sclk_filt;
		next_cs_n_filt = cs_n_filt;
		if (sclk_sync[1] == sclk_sync[2])
		begin
			next_sclk_filt = sclk_sync[2];
		end
		if (cs_sync[1] == cs_sync[2])
		begin
			next_cs_n_filt = cs_sync[2];
		end
	end

	// synchroniser registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sclk_sync <= rbwf_pkg::RBWF_SCLK_SYNC_RST;
			cs_sync <= rbwf_pkg::RBWF_CS_SYNC_RST;
			sclk_filt <= 1'b0;
			cs_n_filt <= 1'b1;
		end
		else
		begin
			sclk_sync <= next_sclk_sync;
			cs_sync <= next_cs_sync;
			sclk_filt <= next_sclk_filt;
			cs_n_filt <= next_cs_n_filt;
		end
	end

	// edges of the filtered pin levels
	assign sclk_rise = next_sclk_filt & ~sclk_filt;
	assign sclk_fall = ~next_sclk_filt & sclk_filt;
	assign cs_fall = ~next_cs_n_filt & cs_n_filt;
	assign cs_rise = next_cs_n_filt & ~cs_n_filt;

	// one word may wait; source stalls until a frame takes it
	assign load_ready = ~pend_valid;

	// pending word capture and hand-off to a frame
	always_comb
	begin
		next_pend_word = pend_word;
		next_pend_valid = pend_valid;
		if (load_valid && load_ready)
		begin
			next_pend_word = rbwf_format(load_kind, load_channel, load_value);
			next_pend_valid = 1'b1;
		end
		else if (sh_load && pend_valid)
		begin
			next_pend_valid = 1'b0;
		end
	end

	// pending word registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pend_word <= rbwf_pkg::RBWF_WORD_RST;
			pend_valid <= 1'b0;
		end
		else
		begin
			pend_word <= next_pend_word;
			pend_valid <= next_pend_valid;
		end
	end

	// frame sequencer: host samples on rising sclk, line moves on falling
	always_comb
	begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_word_sent = 1'b0;
		sh_load = 1'b0;
		sh_shift = 1'b0;
		// an empty frame returns all zeros rather than a stale word
		sh_word = pend_valid ? pend_word : rbwf_pkg::RBWF_WORD_RST;
		case (state)
			rbwf_pkg::RBWF_IDLE:
			begin
				if (cs_fall)
				begin
					sh_load = 1'b1;
					next_bit_cnt = rbwf_pkg::RBWF_CNT_RST;
					next_state = rbwf_pkg::RBWF_SHIFT;
				end
			end
			rbwf_pkg::RBWF_SHIFT:
			begin
				if (cs_rise)
				begin
					next_state = rbwf_pkg::RBWF_IDLE;
				end
				else if (sclk_rise)
				begin
					next_bit_cnt = bit_cnt + 5'h01;
					// RULE9: all sixteen bits seen
					if (bit_cnt == rbwf_pkg::RBWF_LAST_BIT)
					begin
						next_word_sent = 1'b1;
						next_state = rbwf_pkg::RBWF_DONE;
					end
				end
				else if (sclk_fall)
				begin
					sh_shift = 1'b1;
				end
			end
			default:
			begin
				// extra clocks after the word keep shifting, so the drained shifter reads zeros
				if (cs_rise)
				begin
					next_state = rbwf_pkg::RBWF_IDLE;
				end
				else if (sclk_fall)
				begin
					sh_shift = 1'b1;
				end
			end
		endcase
	end

	// frame registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= rbwf_pkg::RBWF_IDLE;
			bit_cnt <= rbwf_pkg::RBWF_CNT_RST;
			word_sent <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			word_sent <= next_word_sent;
		end
	end

	// RULE9: msb-first shifter
	rbwf_shifter u_shifter
	(
		.core_clk(core_clk),
		.rst(rst),
		.load(sh_load),
		.load_word(sh_word),
		.shift(sh_shift),
		.bit_out(sh_bit)
	);

	// serial output drives only inside a frame
	assign sdo = sh_bit;
	assign sdo_oe = (state != rbwf_pkg::RBWF_IDLE);
	assign frame_busy = (state != rbwf_pkg::RBWF_IDLE);

endmodule

// ==== core/rbwf_shifter.sv ====
`timescale 1ns/1ps
module rbwf_shifter
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic [15:0] load_word,
	input wire logic shift,
	// serial bit
	output logic bit_out
);

	logic [15:0] shreg;
	logic [15:0] next_shreg;

	// load wins over shift so a new frame never starts mid-word
	always_comb
	begin
		next_shreg = shreg;
		if (load)
		begin
			next_shreg = load_word;
		end
		else if (shift)
		begin
			// RULE9: msb leaves first
			next_shreg = {shreg[14:0], 1'b0};
		end
	end

	// shift register
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			shreg <= rbwf_pkg::RBWF_WORD_RST;
		end
		else
		begin
			shreg <= next_shreg;
		end
	end

	// line always shows the top bit
	assign bit_out = shreg[15];

endmodule

// ==== sim/rbwf_checker.sv ====
`timescale 1ns/1ps
// frame and handshake checks at the formatter pins
module rbwf_checker
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// word source
	input wire logic load_valid,
	input wire rbwf_pkg::rbwf_kind_t load_kind,
	input wire logic [2:0] load_channel,
	input wire logic [11:0] load_value,
	input wire logic load_ready,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	// status
	input wire logic frame_busy,
	input wire logic word_sent
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// msb that the word just taken must show when its frame opens
	logic tag_msb;
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tag_msb <= 1'b0;
		end
		else if (load_valid && load_ready)
		begin
			tag_msb <= (load_kind == rbwf_pkg::RBWF_KIND_TEMP) ||
				(load_kind == rbwf_pkg::RBWF_KIND_OUTSET);
		end
	end
	// word offered while the slot is empty
	sequence s_take;
		load_valid && load_ready;
	endsequence
	// select held low long enough to clear the pin filter
	sequence s_select;
		$fell(cs_n) ##1 !cs_n [*7];
	endsequence
	a_slot_fills: assert property (s_take |=> !load_ready)
		else $error("slot did not fill");
	a_slot_frees: assert property ($rose(load_ready) |-> ##[0:1] frame_busy)
		else $error("slot freed outside a frame");
	a_oe_tracks_busy: assert property (sdo_oe == frame_busy)
		else $error("output enable and busy differ");
	a_sent_single: assert property (word_sent |=> !word_sent)
		else $error("word sent pulse too long");
	a_sent_framed: assert property (word_sent |-> frame_busy)
		else $error("word sent outside a frame");
	a_sent_late: assert property (word_sent |-> $past(frame_busy, 16))
		else $error("word sent before 16 bits");
	a_busy_selected: assert property ($rose(frame_busy) |-> !cs_n)
		else $error("frame started without select");
	a_select_starts: assert property (s_select |-> frame_busy)
		else $error("select did not start a frame");
	a_deselect_ends: assert property (cs_n [*8] |-> !frame_busy)
		else $error("frame outlived deselect");
	a_first_tag_bit: assert property
		($rose(frame_busy) && $rose(load_ready) |-> sdo == tag_msb)
		else $error("first bit does not match word kind");
	a_empty_frame_zero: assert property
		($rose(frame_busy) && !$rose(load_ready) |-> !sdo)
		else $error("empty frame did not start with zero");
endmodule

// ==== sim/rbwf_host.sv ====
`timescale 1ns/1ps
// serial host, mode 0: sclk idles low and stands still outside frames
module rbwf_host
(
	// clock
	input wire logic core_clk,
	// serial pins
	output logic sclk,
	output logic cs_n,
	input wire logic sdo
);
	// idle levels from time zero
	initial
	begin
		sclk = 1'h0;
		cs_n = 1'h1;
	end
	// hold a pin level; the device filter needs 4 cycles, so keep h above that
	task automatic hold(input int h);
		repeat (h) @(posedge core_clk);
		#1;
	endtask
	task automatic xfer(input int h, output logic [15:0] w);
		w = 16'h0000;
		cs_n = 1'h0;
		hold(h);
		for (int i = 0; i < 16; i++)
		begin
			w = {w[14:0], sdo};
			sclk = 1'h1;
			hold(h);
			sclk = 1'h0;
			hold(h);
		end
		cs_n = 1'h1;
		hold(h);
	endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic core_clk;
	logic rst;
	logic load_valid;
	rbwf_pkg::rbwf_kind_t load_kind;
	logic [2:0] load_channel;
	logic [11:0] load_value;
	logic load_ready;
	logic sclk;
	logic cs_n;
	logic sdo;
	logic sdo_oe;
	logic frame_busy;
	logic word_sent;
	logic [15:0] w;
	logic [15:0] e;
	logic [11:0] v;
	int mismatches = 0;
	int checked = 0;
	int sent = 0;
	int s0;
	rbwf_formatter u_rbwf_formatter(.core_clk(core_clk), .rst(rst), .load_valid(load_valid),
		.load_kind(load_kind), .load_channel(load_channel), .load_value(load_value),
		.load_ready(load_ready), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
		.frame_busy(frame_busy), .word_sent(word_sent));
	rbwf_host u_rbwf_host(.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdo(sdo));
	// clock
	initial
	begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	// count completion pulses
	always @(posedge core_clk)
		if (word_sent === 1'h1)
			sent++;
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input string n, input logic [15:0] x, input logic [15:0] s);
		checked++;
		if (s !== x)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// offer one word; the slot is empty here, so it is taken at once
	task automatic load(input rbwf_pkg::rbwf_kind_t k, input logic [2:0] c, input logic [11:0] x);
		load_kind = k;
		load_channel = c;
		load_value = x;
		load_valid = 1'h1;
		cyc(1);
		load_valid = 1'h0;
		check("load_ready", 16'h0000, {15'h0000, load_ready});
	endtask
	// main sequence: empty frame, then every kind, channel 0..7, prompt and slow host
	initial
	begin
		rst = 1'h1;
		load_valid = 1'h0;
		load_kind = rbwf_pkg::RBWF_KIND_CONV;
		load_channel = 3'h0;
		load_value = 12'h000;
		cyc(3);
		rst = 1'h0;
		cyc(4);
		u_rbwf_host.xfer(6, w);
		check("empty_word", 16'h0000, w);
		s0 = sent;
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 7) ? 12'hfff : 12'(32'h9c3 * i);
			load(rbwf_pkg::rbwf_kind_t'(2'(i)), 3'(i), v);
			if (i == 0)
			begin
				// a second offer while a word waits must be refused
				load_kind = rbwf_pkg::RBWF_KIND_OUTSET;
				load_channel = 3'h7;
				load_value = 12'h5a5;
				load_valid = 1'h1;
				cyc(3);
				load_valid = 1'h0;
				check("refused_ready", 16'h0000, {15'h0000, load_ready});
			end
			e = (i % 4 == 2) ? {1'h1, 3'(i), v} : (i % 4 == 1) ? {4'h8, v} : {1'h0, 3'(i), v};
			u_rbwf_host.xfer(6 + (i % 2) * 4, w);
			check("readback_word", e, w);
		end
		check("word_sent_count", 16'h0008, 16'(sent - s0));
		finish_test();
	end
	// watchdog well beyond nine slow frames
	initial
	begin
		#1000000;
		mismatches++;
		finish_test();
	end
endmodule
bind rbwf_formatter rbwf_checker u_rbwf_checker(.core_clk(core_clk), .rst(rst),
	.load_valid(load_valid), .load_kind(load_kind), .load_channel(load_channel),
	.load_value(load_value), .load_ready(load_ready), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
	.sdo_oe(sdo_oe), .frame_busy(frame_busy), .word_sent(word_sent));
